// >>> common/homing_pkg.sv
package homing_pkg;

  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MS_PS = 1000000000;
  localparam int MS_CYCLES = MS_PS / CLK_PERIOD_PS;

  // Register offsets on the plain port
  localparam logic [3:0] ADDR_METHOD = 4'h0;
  localparam logic [3:0] ADDR_RAMP = 4'h1;
  localparam logic [3:0] ADDR_FAST = 4'h2;
  localparam logic [3:0] ADDR_SLOW = 4'h3;
  localparam logic [3:0] ADDR_OFFSET = 4'h4;
  localparam logic [3:0] ADDR_WINDOW = 4'h5;
  localparam logic [3:0] ADDR_HOLD = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;

  // Values after reset and limits
  localparam logic [15:0] METHOD_RST = 16'h0000;
  localparam logic [15:0] RAMP_RST = 16'h01F4;
  localparam logic [15:0] FAST_RST = 16'h01F4;
  localparam logic [15:0] SLOW_RST = 16'h0064;
  localparam logic [31:0] OFFSET_RST = 32'h00000000;
  localparam logic [15:0] WINDOW_RST = 16'h0005;
  localparam logic [15:0] HOLD_RST = 16'h000A;
  localparam logic [15:0] METHOD_MAX = 16'h0063;

  // Status field positions
  localparam int ST_STATE_LSB = 0;
  localparam int ST_DRIVE_BIT = 3;
  localparam int ST_DONE_BIT = 4;
  localparam int ST_ERROR_BIT = 5;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LEG1 = 3'b001,
    ST_LEG2 = 3'b010,
    ST_FINAL = 3'b011,
    ST_SETTLE = 3'b100,
    ST_DONE = 3'b101
  } state_t;

  typedef enum logic [1:0] {SW_HOME = 2'b00, SW_FWD = 2'b01, SW_REV = 2'b10} sw_sel_t;
  typedef enum logic [1:0] {FM_Z_QUAL = 2'b00, FM_Z_ANY = 2'b01, FM_SW_LOW = 2'b10} fin_mode_t;
  typedef enum logic [1:0] {GO_LEG1 = 2'b00, GO_LEG2 = 2'b01, GO_FINAL = 2'b10, GO_NOW = 2'b11} start_t;

  typedef struct packed {logic home; logic fwd; logic rev;} sw_t;
  typedef struct packed {logic fwd; logic fast; sw_sel_t watch; logic exit_high;} leg_t;
  typedef struct packed {logic fwd; logic fast; sw_sel_t watch; fin_mode_t mode;} fin_t;
  typedef struct packed {logic valid; start_t start; leg_t leg1; leg_t leg2; fin_t fin;} plan_t;

endpackage

// >>> logic/servo_homing_sequencer.sv
// Operation
// RULE1: Method 0..99 selects procedure; writable only while drive disabled; effective at once.
// RULE2: Speed ramps up and down with programmable ramp time in ms, default 500.
// RULE3: First (fast) homing speed in rpm, default 500, used for coarse search.
// RULE4: Second (slow) homing speed in rpm, default 100, used for final approach.
// RULE5: Done only when inside zero window, speed reference zero, held for hold time.
// RULE6: Method 1, negative limit low: reverse fast, on high forward slow, index while low.
// RULE7: Method 1, negative limit high: forward slow, zero at index once limit low.
// RULE8: Method 2, positive limit low: forward fast, on high reverse slow, index while low.
// RULE9: Method 2, positive limit high: reverse slow, zero at index once limit low.
// RULE10: Method 3: forward fast until home high, then reverse slow, index with home low.
// RULE11: Method 4, home low: forward fast, on high reverse slow, next index is zero.
// RULE12: Method 4, home high: reverse slow, forward fast, reverse slow, first index zero.
// RULE13: Method 5, home high: forward slow, zero at first index with home low.
// RULE14: Method 5, home low: reverse fast, on high forward slow, index with home low.
// RULE15: Method 6, home high: forward slow, reverse fast, forward slow, first index zero.
// RULE16: Method 6, home low: reverse fast, on high forward slow, first index zero.
// RULE17: Methods 17 and 18 home on negative and positive limit without index.
// RULE18: Methods 33 and 34 home on index only; method 35 takes current position.
// RULE19: Run starts on trigger rising; case chosen from switch levels sampled then.
// RULE20: At zero point the signed 32-bit offset is loaded into the position reference.
`timescale 1ns/100ps
module servo_homing_sequencer #(
  parameter int MS_CYCLES = homing_pkg::MS_CYCLES
) (
  input wire logic mclk, // 200 MHz clock
  input wire logic reset_n, // Async reset, active low
  input wire logic drive_enable, // Drive enabled, pin
  input wire logic homing_trigger_input, // Start homing, pin
  input wire logic home_switch_input, // Home switch, pin
  input wire logic forward_limit_input, // Positive limit switch, pin
  input wire logic reverse_limit_input, // Negative limit switch, pin
  input wire logic index_pulse, // Encoder index, pin
  input wire logic [31:0] encoder_position, // Axis position, same clock
  input wire logic [31:0] position_speed_reference, // Position-mode speed ref, same clock
  input wire logic [3:0] reg_addr, // Register address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  output logic signed [16:0] velocity_cmd, // Signed speed command, rpm
  output logic position_load, // One-cycle load of position reference
  output logic [31:0] position_load_value, // Value to load
  output logic homing_done_output // Homing complete
);

  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic trig_d_reg;
  logic idx_d_reg;
  homing_pkg::sw_t sw;
  logic drive_en;
  logic trig_rise;
  logic idx_rise;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
      trig_d_reg <= 1'b0;
      idx_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {drive_enable, homing_trigger_input, home_switch_input,
                    forward_limit_input, reverse_limit_input, index_pulse};
      sync2_reg <= sync1_reg;
      trig_d_reg <= sync2_reg[4];
      idx_d_reg <= sync2_reg[0];
    end
  end

  assign drive_en = sync2_reg[5];
  assign sw = sync2_reg[3:1];
  assign trig_rise = sync2_reg[4] & ~trig_d_reg;
  assign idx_rise = sync2_reg[0] & ~idx_d_reg;

  // Registers
  logic [15:0] method_reg;
  logic [15:0] ramp_time_reg;
  logic [15:0] fast_speed_reg;
  logic [15:0] slow_speed_reg;
  logic [31:0] offset_reg;
  logic [15:0] window_reg;
  logic [15:0] hold_time_reg;
  logic [31:0] rdata_reg;
  logic error_reg;
  logic done_reg;
  homing_pkg::state_t state_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      method_reg <= homing_pkg::METHOD_RST;
      ramp_time_reg <= homing_pkg::RAMP_RST;
      fast_speed_reg <= homing_pkg::FAST_RST;
      slow_speed_reg <= homing_pkg::SLOW_RST;
      offset_reg <= homing_pkg::OFFSET_RST;
      window_reg <= homing_pkg::WINDOW_RST;
      hold_time_reg <= homing_pkg::HOLD_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        homing_pkg::ADDR_METHOD: begin
          if (!drive_en && reg_wdata[15:0] <= homing_pkg::METHOD_MAX) begin
            method_reg <= reg_wdata[15:0]; // RULE1
          end
        end
        homing_pkg::ADDR_RAMP: ramp_time_reg <= {1'b0, reg_wdata[14:0]}; // RULE2
        homing_pkg::ADDR_FAST: fast_speed_reg <= {1'b0, reg_wdata[14:0]}; // RULE3
        homing_pkg::ADDR_SLOW: slow_speed_reg <= {1'b0, reg_wdata[14:0]}; // RULE4
        homing_pkg::ADDR_OFFSET: offset_reg <= reg_wdata; // RULE20
        homing_pkg::ADDR_WINDOW: window_reg <= {1'b0, reg_wdata[14:0]};
        homing_pkg::ADDR_HOLD: hold_time_reg <= {1'b0, reg_wdata[14:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        homing_pkg::ADDR_METHOD: rdata_reg <= {16'h0000, method_reg};
        homing_pkg::ADDR_RAMP: rdata_reg <= {16'h0000, ramp_time_reg};
        homing_pkg::ADDR_FAST: rdata_reg <= {16'h0000, fast_speed_reg};
        homing_pkg::ADDR_SLOW: rdata_reg <= {16'h0000, slow_speed_reg};
        homing_pkg::ADDR_OFFSET: rdata_reg <= offset_reg;
        homing_pkg::ADDR_WINDOW: rdata_reg <= {16'h0000, window_reg};
        homing_pkg::ADDR_HOLD: rdata_reg <= {16'h0000, hold_time_reg};
        homing_pkg::ADDR_STATUS: rdata_reg <= {26'h0, error_reg, done_reg,
                                               drive_en, state_reg};
        default: rdata_reg <= 32'h00000000;
      endcase
    end else begin
      rdata_reg <= 32'h00000000;
    end
  end

  // Motion plan per method and sampled switch levels
  function automatic homing_pkg::leg_t mk_leg(input logic f, input logic fa,
                                              input homing_pkg::sw_sel_t w, input logic e);
    mk_leg = {f, fa, w, e};
  endfunction

  function automatic homing_pkg::fin_t mk_fin(input logic f, input homing_pkg::sw_sel_t w,
                                              input homing_pkg::fin_mode_t m);
    mk_fin = {f, 1'b0, w, m};
  endfunction

  function automatic homing_pkg::plan_t make_plan(input logic [15:0] m,
                                                  input homing_pkg::sw_t s);
    homing_pkg::plan_t p;
    p = '0;
    p.valid = 1'b1;
    case (m)
      16'h0001: begin
        p.leg2 = mk_leg(1'b0, 1'b1, homing_pkg::SW_REV, 1'b1); // RULE6
        p.fin = mk_fin(1'b1, homing_pkg::SW_REV, homing_pkg::FM_Z_QUAL); // RULE6
        p.start = s.rev ? homing_pkg::GO_FINAL : homing_pkg::GO_LEG2; // RULE7
      end
      16'h0002: begin
        p.leg2 = mk_leg(1'b1, 1'b1, homing_pkg::SW_FWD, 1'b1); // RULE8
        p.fin = mk_fin(1'b0, homing_pkg::SW_FWD, homing_pkg::FM_Z_QUAL); // RULE8
        p.start = s.fwd ? homing_pkg::GO_FINAL : homing_pkg::GO_LEG2; // RULE9
      end
      16'h0003: begin
        p.leg2 = mk_leg(1'b1, 1'b1, homing_pkg::SW_HOME, 1'b1); // RULE10
        p.fin = mk_fin(1'b0, homing_pkg::SW_HOME, homing_pkg::FM_Z_QUAL); // RULE10
        p.start = s.home ? homing_pkg::GO_FINAL : homing_pkg::GO_LEG2; // RULE10
      end
      16'h0004: begin
        p.leg1 = mk_leg(1'b0, 1'b0, homing_pkg::SW_HOME, 1'b0); // RULE12
        p.leg2 = mk_leg(1'b1, 1'b1, homing_pkg::SW_HOME, 1'b1); // RULE11
        p.fin = mk_fin(1'b0, homing_pkg::SW_HOME, homing_pkg::FM_Z_ANY); // RULE11
        p.start = s.home ? homing_pkg::GO_LEG1 : homing_pkg::GO_LEG2; // RULE12
      end
      16'h0005: begin
        p.leg2 = mk_leg(1'b0, 1'b1, homing_pkg::SW_HOME, 1'b1); // RULE14
        p.fin = mk_fin(1'b1, homing_pkg::SW_HOME, homing_pkg::FM_Z_QUAL); // RULE13
        p.start = s.home ? homing_pkg::GO_FINAL : homing_pkg::GO_LEG2; // RULE13
      end
      16'h0006: begin
        p.leg1 = mk_leg(1'b1, 1'b0, homing_pkg::SW_HOME, 1'b0); // RULE15
        p.leg2 = mk_leg(1'b0, 1'b1, homing_pkg::SW_HOME, 1'b1); // RULE16
        p.fin = mk_fin(1'b1, homing_pkg::SW_HOME, homing_pkg::FM_Z_ANY); // RULE16
        p.start = s.home ? homing_pkg::GO_LEG1 : homing_pkg::GO_LEG2; // RULE15
      end
      16'h0011: begin
        p.leg2 = mk_leg(1'b0, 1'b1, homing_pkg::SW_REV, 1'b1); // RULE17
        p.fin = mk_fin(1'b1, homing_pkg::SW_REV, homing_pkg::FM_SW_LOW); // RULE17
        p.start = s.rev ? homing_pkg::GO_FINAL : homing_pkg::GO_LEG2;
      end
      16'h0012: begin
        p.leg2 = mk_leg(1'b1, 1'b1, homing_pkg::SW_FWD, 1'b1); // RULE17
        p.fin = mk_fin(1'b0, homing_pkg::SW_FWD, homing_pkg::FM_SW_LOW); // RULE17
        p.start = s.fwd ? homing_pkg::GO_FINAL : homing_pkg::GO_LEG2;
      end
      16'h0021: begin
        p.fin = mk_fin(1'b0, homing_pkg::SW_HOME, homing_pkg::FM_Z_ANY); // RULE18
        p.start = homing_pkg::GO_FINAL;
      end
      16'h0022: begin
        p.fin = mk_fin(1'b1, homing_pkg::SW_HOME, homing_pkg::FM_Z_ANY); // RULE18
        p.start = homing_pkg::GO_FINAL;
      end
      16'h0023: p.start = homing_pkg::GO_NOW; // RULE18
      default: p.valid = 1'b0;
    endcase
    return p;
  endfunction

  function automatic logic watch_lvl(input homing_pkg::sw_sel_t w, input homing_pkg::sw_t s);
    case (w)
      homing_pkg::SW_FWD: watch_lvl = s.fwd;
      homing_pkg::SW_REV: watch_lvl = s.rev;
      default: watch_lvl = s.home;
    endcase
  endfunction

  homing_pkg::plan_t plan_reg;
  homing_pkg::plan_t new_plan;
  logic idle_like;
  logic trig_go;
  logic fin_hit;
  logic zero_event;
  logic hold_ok;

  assign new_plan = make_plan(method_reg, sw); // RULE19
  assign idle_like = (state_reg == homing_pkg::ST_IDLE) || (state_reg == homing_pkg::ST_DONE);
  assign trig_go = trig_rise && drive_en && idle_like; // RULE19

  always_comb begin
    case (plan_reg.fin.mode)
      homing_pkg::FM_Z_QUAL: fin_hit = idx_rise && !watch_lvl(plan_reg.fin.watch, sw);
      homing_pkg::FM_SW_LOW: fin_hit = !watch_lvl(plan_reg.fin.watch, sw);
      default: fin_hit = idx_rise;
    endcase
  end

  assign zero_event = ((state_reg == homing_pkg::ST_FINAL) && fin_hit) ||
                      (trig_go && new_plan.valid && new_plan.start == homing_pkg::GO_NOW);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= homing_pkg::ST_IDLE;
      plan_reg <= '0;
      error_reg <= 1'b0;
    end else if (!drive_en && !idle_like) begin
      state_reg <= homing_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        homing_pkg::ST_IDLE, homing_pkg::ST_DONE: begin
          if (trig_go) begin
            plan_reg <= new_plan;
            error_reg <= !new_plan.valid;
            if (new_plan.valid) begin
              case (new_plan.start)
                homing_pkg::GO_LEG1: state_reg <= homing_pkg::ST_LEG1;
                homing_pkg::GO_LEG2: state_reg <= homing_pkg::ST_LEG2;
                homing_pkg::GO_FINAL: state_reg <= homing_pkg::ST_FINAL;
                default: state_reg <= homing_pkg::ST_SETTLE; // RULE18
              endcase
            end
          end
        end
        homing_pkg::ST_LEG1: begin
          if (watch_lvl(plan_reg.leg1.watch, sw) == plan_reg.leg1.exit_high) begin
            state_reg <= homing_pkg::ST_LEG2; // RULE12
          end
        end
        homing_pkg::ST_LEG2: begin
          if (watch_lvl(plan_reg.leg2.watch, sw) == plan_reg.leg2.exit_high) begin
            state_reg <= homing_pkg::ST_FINAL;
          end
        end
        homing_pkg::ST_FINAL: begin
          if (fin_hit) begin
            state_reg <= homing_pkg::ST_SETTLE;
          end
        end
        homing_pkg::ST_SETTLE: begin
          if (hold_ok) begin
            state_reg <= homing_pkg::ST_DONE; // RULE5
          end
        end
        default: state_reg <= homing_pkg::ST_IDLE;
      endcase
    end
  end

  logic load_reg;
  logic [31:0] load_value_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      load_reg <= 1'b0;
      load_value_reg <= 32'h00000000;
    end else begin
      load_reg <= zero_event; // RULE20
      if (zero_event) begin
        load_value_reg <= offset_reg; // RULE20
      end
    end
  end

  // Speed target and ramp
  logic moving;
  logic tgt_fwd;
  logic tgt_fast;
  logic [15:0] tgt_mag;
  logic signed [16:0] tgt_vel;

  always_comb begin
    moving = 1'b1;
    tgt_fwd = plan_reg.fin.fwd;
    tgt_fast = 1'b0;
    case (state_reg)
      homing_pkg::ST_LEG1: begin
        tgt_fwd = plan_reg.leg1.fwd;
        tgt_fast = plan_reg.leg1.fast;
      end
      homing_pkg::ST_LEG2: begin
        tgt_fwd = plan_reg.leg2.fwd;
        tgt_fast = plan_reg.leg2.fast;
      end
      homing_pkg::ST_FINAL: tgt_fast = 1'b0;
      default: moving = 1'b0;
    endcase
    tgt_mag = !moving ? 16'h0000 : (tgt_fast ? fast_speed_reg : slow_speed_reg); // RULE3 RULE4
    tgt_vel = tgt_fwd ? $signed({1'b0, tgt_mag}) : -$signed({1'b0, tgt_mag});
  end

  // Rate is first speed per ramp time; stepping through zero handles reversals
  logic [33:0] acc_reg;
  logic [33:0] ramp_thresh;
  logic [33:0] acc_sum;
  logic signed [16:0] vel_reg;

  assign ramp_thresh = 34'(ramp_time_reg) * 34'(MS_CYCLES);
  assign acc_sum = acc_reg + ((fast_speed_reg == 16'h0000) ? 34'h1 : 34'(fast_speed_reg));

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      acc_reg <= 34'h0;
      vel_reg <= 17'sh0;
    end else if (ramp_time_reg == 16'h0000 || vel_reg == tgt_vel) begin
      vel_reg <= tgt_vel;
      acc_reg <= 34'h0;
    end else if (acc_sum >= ramp_thresh) begin
      acc_reg <= acc_sum - ramp_thresh;
      vel_reg <= (vel_reg < tgt_vel) ? vel_reg + 17'sh1 : vel_reg - 17'sh1; // RULE2
    end else begin
      acc_reg <= acc_sum;
    end
  end

  // Completion: inside window, no speed reference, held for hold time
  logic signed [32:0] pos_diff;
  logic [32:0] pos_mag;
  logic settle_cond;
  logic settling;
  logic [31:0] ms_cnt_reg;
  logic [15:0] hold_ms_reg;

  assign pos_diff = $signed({encoder_position[31], encoder_position}) -
                    $signed({offset_reg[31], offset_reg});
  assign pos_mag = pos_diff[32] ? 33'(-pos_diff) : 33'(pos_diff);
  assign settle_cond = (pos_mag <= 33'(window_reg)) && (position_speed_reference == 32'h0);
  assign settling = (state_reg == homing_pkg::ST_SETTLE) || (state_reg == homing_pkg::ST_DONE);
  assign hold_ok = settling && settle_cond && (hold_ms_reg >= hold_time_reg); // RULE5

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt_reg <= 32'h0;
      hold_ms_reg <= 16'h0000;
    end else if (!settling || !settle_cond) begin
      ms_cnt_reg <= 32'h0;
      hold_ms_reg <= 16'h0000;
    end else if (ms_cnt_reg == 32'(MS_CYCLES - 1)) begin
      ms_cnt_reg <= 32'h0;
      if (hold_ms_reg != 16'hFFFF) begin
        hold_ms_reg <= hold_ms_reg + 16'h0001;
      end
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= hold_ok; // RULE5
    end
  end

  assign reg_rdata = rdata_reg;
  assign velocity_cmd = vel_reg;
  assign position_load = load_reg;
  assign position_load_value = load_value_reg;
  assign homing_done_output = done_reg;

  sequence s_start(logic [15:0] m, logic lvl);
    trig_go && method_reg == m && lvl;
  endsequence

  property p_method_locked;
    @(posedge mclk) disable iff (!reset_n)
    (reg_wr && reg_addr == homing_pkg::ADDR_METHOD && drive_en) |=> $stable(method_reg);
  endproperty
  a_method_locked: assert property (p_method_locked) else $error("method changed while enabled"); // RULE1

  property p_ramp_step;
    @(posedge mclk) disable iff (!reset_n)
    (ramp_time_reg != 16'h0000 && $stable(ramp_time_reg)) |=>
      (vel_reg - $past(vel_reg) <= 17'sh1) && ($past(vel_reg) - vel_reg <= 17'sh1);
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("speed jumped under ramp"); // RULE2

  property p_fast_leg;
    @(posedge mclk) disable iff (!reset_n)
    (state_reg == homing_pkg::ST_LEG2 && ramp_time_reg == 16'h0000) |=>
      (vel_reg == fast_speed_reg || -vel_reg == fast_speed_reg || $changed(state_reg));
  endproperty
  a_fast_leg: assert property (p_fast_leg) else $error("coarse leg not at first speed"); // RULE3

  property p_slow_final;
    @(posedge mclk) disable iff (!reset_n)
    state_reg == homing_pkg::ST_FINAL |-> tgt_mag == slow_speed_reg;
  endproperty
  a_slow_final: assert property (p_slow_final) else $error("final approach not at second speed"); // RULE4

  property p_done_cause;
    @(posedge mclk) disable iff (!reset_n)
    homing_done_output |-> $past(settle_cond) && $past(hold_ms_reg) >= $past(hold_time_reg);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without settled position"); // RULE5

  property p_m1_low;
    @(posedge mclk) disable iff (!reset_n)
    s_start(16'h0001, !sw.rev) |=> state_reg == homing_pkg::ST_LEG2 && tgt_vel < 0;
  endproperty
  a_m1_low: assert property (p_m1_low) else $error("method 1 low case wrong start"); // RULE6

  property p_m1_high;
    @(posedge mclk) disable iff (!reset_n)
    s_start(16'h0001, sw.rev) |=> state_reg == homing_pkg::ST_FINAL && tgt_vel > 0;
  endproperty
  a_m1_high: assert property (p_m1_high) else $error("method 1 high case wrong start"); // RULE7

  property p_m35;
    @(posedge mclk) disable iff (!reset_n)
    s_start(16'h0023, 1'b1) |=> position_load && state_reg == homing_pkg::ST_SETTLE;
  endproperty
  a_m35: assert property (p_m35) else $error("method 35 did not zero at once"); // RULE18

  property p_offset_load;
    @(posedge mclk) disable iff (!reset_n)
    (state_reg == homing_pkg::ST_FINAL && fin_hit) |=>
      position_load && position_load_value == $past(offset_reg) ##1 !position_load;
  endproperty
  a_offset_load: assert property (p_offset_load) else $error("offset not loaded at zero"); // RULE20

endmodule // servo_homing_sequencer

// >>> test/axis_motion_model.sv
`timescale 1ns/100ps
module axis_motion_model (
  input wire logic mclk, // Clock
  input wire logic preset, // Load start position
  input wire logic [31:0] preset_pos, // Start position
  input wire logic signed [16:0] velocity_cmd, // Speed command
  input wire logic position_load, // Redefine position
  input wire logic [31:0] position_load_value, // New position
  output logic [31:0] encoder_position, // Position
  output logic [31:0] position_speed_reference, // Speed reference
  output logic home_switch_input, // Home switch
  output logic forward_limit_input, // Positive limit
  output logic reverse_limit_input, // Negative limit
  output logic index_pulse // Index
);
  logic signed [31:0] pos;
  always_ff @(posedge mclk) begin
    if (preset)
      pos <= preset_pos;
    else if (position_load)
      pos <= position_load_value;
    else
      pos <= pos + 32'(velocity_cmd);
  end
  assign encoder_position = pos;
  assign position_speed_reference = 32'(velocity_cmd);
  assign home_switch_input = pos >= 32'sh2710 && pos <= 32'sh4E20;
  assign forward_limit_input = pos >= 32'sh9C40;
  assign reverse_limit_input = pos <= -32'sh9C40;
  // Index 128 units wide, so at least two cycles at test speeds
  assign index_pulse = pos[10:7] == 4'h0;
endmodule // axis_motion_model

// >>> test/servo_homing_sequencer_tb_top.sv
`timescale 1ns/100ps
module servo_homing_sequencer_tb_top;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic drive_enable = 1'b0;
  logic trig = 1'b0;
  logic preset = 1'b1;
  logic [31:0] preset_pos = 32'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, enc, sref, load_val, r;
  logic signed [16:0] vel;
  logic home, fwd, rev, idx, load, done;
  int fails = 0;
  int check_count = 0;
  int seed = 48914;
  int meth[11] = '{1, 2, 3, 4, 5, 6, 17, 18, 33, 34, 35};
  logic [31:0] dflt[9] = '{32'h0, 32'h1F4, 32'h1F4, 32'h64, 32'h0, 32'h5, 32'hA, 32'h0, 32'h0};
  always #2.5 mclk = ~mclk;
  servo_homing_sequencer #(.MS_CYCLES(20)) i_dut (.mclk(mclk), .reset_n(reset_n),
    .drive_enable(drive_enable), .homing_trigger_input(trig), .home_switch_input(home),
    .forward_limit_input(fwd), .reverse_limit_input(rev), .index_pulse(idx),
    .encoder_position(enc), .position_speed_reference(sref), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .velocity_cmd(vel), .position_load(load), .position_load_value(load_val),
    .homing_done_output(done));
  axis_motion_model i_axis (.mclk(mclk), .preset(preset), .preset_pos(preset_pos),
    .velocity_cmd(vel), .position_load(load), .position_load_value(load_val),
    .encoder_position(enc), .position_speed_reference(sref), .home_switch_input(home),
    .forward_limit_input(fwd), .reverse_limit_input(rev), .index_pulse(idx));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Expected opening move: forward or reverse, fast or slow
  function automatic logic [31:0] first_speed(int m, bit h, int f, int s);
    bit up;
    int v;
    up = (m == 1 || m == 17 || m == 5 || m == 6) ? h : !h;
    up = (m == 33) ? 1'b0 : (m == 34) ? 1'b1 : up;
    v = (h || m >= 33) ? s : f;
    return (m == 35) ? 32'h0 : 32'(up ? v : -v);
  endfunction
  function automatic logic [31:0] start_pos(int m, bit h, int f, int s);
    logic [31:0] fs;
    fs = first_speed(m, h, f, s);
    if (!h)
      return fs[31] ? 32'h7530 : 32'h0;
    return (m == 1 || m == 17) ? -32'hAFC8 : (m == 2 || m == 18) ? 32'hAFC8 : 32'h3A98;
  endfunction
  task automatic home_run(int m, bit h, int f, int s, logic [31:0] off);
    int n;
    drive_enable <= 1'b0;
    repeat (4) @(posedge mclk);
    wr(homing_pkg::ADDR_METHOD, 32'(m));
    wr(homing_pkg::ADDR_FAST, 32'(f));
    wr(homing_pkg::ADDR_SLOW, 32'(s));
    wr(homing_pkg::ADDR_OFFSET, off);
    preset_pos <= start_pos(m, h, f, s);
    preset <= 1'b1;
    drive_enable <= 1'b1;
    repeat (4) @(posedge mclk);
    preset <= 1'b0;
    trig <= 1'b1;
    n = 0;
    while (m != 35 && vel === 17'h0 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk(32'(vel), first_speed(m, h, f, s));
    n = 0;
    while (load !== 1'b1 && n < 20000) begin
      @(negedge mclk);
      n++;
    end
    chk(load, 1);
    chk(load_val, off);
    @(posedge mclk);
    trig <= 1'b0;
    repeat (10) @(negedge mclk);
    chk(done, 0);
    n = 0;
    while (done !== 1'b1 && n < 500) begin
      @(negedge mclk);
      n++;
    end
    chk(done, 1);
    @(posedge mclk);
    preset_pos <= off + 32'h64;
    preset <= 1'b1;
    @(posedge mclk);
    preset <= 1'b0;
    repeat (4) @(negedge mclk);
    chk(done, 0);
    $display("run of method %0d case %0d done", m, h);
  endtask
  initial begin
    #450000;
    fails++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    wr(homing_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
    wr(4'h8, 32'h1);
    for (int a = 0; a < 9; a++) begin
      rd(4'(a), r);
      chk(r, dflt[a]);
    end
    $display("register defaults done");
    wr(homing_pkg::ADDR_HOLD, 32'h2);
    wr(homing_pkg::ADDR_RAMP, 32'h0);
    foreach (meth[i]) begin
      home_run(meth[i], 1'b0, 40, 10, 32'h1234_5678);
      home_run(meth[i], 1'b1, 40, 10, -32'h100);
    end
    drive_enable <= 1'b0;
    repeat (4) @(posedge mclk);
    wr(homing_pkg::ADDR_METHOD, 32'h7);
    wr(homing_pkg::ADDR_METHOD, 32'h64);
    drive_enable <= 1'b1;
    repeat (4) @(posedge mclk);
    wr(homing_pkg::ADDR_METHOD, 32'h3);
    rd(homing_pkg::ADDR_METHOD, r);
    chk(r, 32'h7);
    trig <= 1'b1;
    repeat (10) @(negedge mclk);
    rd(homing_pkg::ADDR_STATUS, r);
    chk(r[5], 1);
    chk(32'(vel), 32'h0);
    @(posedge mclk);
    trig <= 1'b0;
    home_run(34, 1'b0, 40, 10, 32'h0);
    wr(homing_pkg::ADDR_RAMP, 32'h14);
    trig <= 1'b1;
    repeat (60) @(negedge mclk);
    chk(vel > 0 && vel < 10, 1);
    drive_enable <= 1'b0;
    repeat (1000) @(negedge mclk);
    chk(32'(vel), 32'h0);
    trig <= 1'b0;
    wr(homing_pkg::ADDR_RAMP, 32'h0);
    $display("ramp and refusal done");
    repeat (4) home_run(meth[($random(seed) & 32'hFFFF) % 11], 1'($random(seed)),
      20 + ($random(seed) & 32'h1F), 5 + ($random(seed) & 32'hF), $random(seed));
    conclude();
  end
endmodule // servo_homing_sequencer_tb_top
